// *** hdl/rot_sub_skip_exec.sv ***
// Execution datapath for rotates, subtraction, set, nibble exchange and skips
`timescale 1ns/1ns
module rot_sub_skip_exec (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    // From the instruction decoder
    input  wire logic                   op_valid,
    input  wire logic [4:0]             op_code,
    input  wire logic [7:0]             imm_data,
    input  wire logic [2:0]             bit_sel,
    // Data memory read port
    input  wire logic [7:0]             mem_rdata,
    // Data memory write port
    output logic                        mem_we,
    output logic      [7:0]             mem_wdata,
    // Core state
    output logic      [7:0]             working_register,
    output logic      [5:0]             status_flags,
    // Sequencing
    output logic                        busy,
    output logic                        skip_pulse
);
    exec_pkg::op_type op;
    logic [7:0] work_reg;
    logic [5:0] flag_reg;
    logic       mem_we_reg;
    logic [7:0] mem_wdata_reg;
    logic       busy_reg;
    logic       skip_reg;

    wire logic       second_cycle;
    wire logic       squash_next;
    wire logic       live;
    wire logic       cy;
    wire logic [7:0] sub_rhs;
    wire logic       sub_bin;
    wire logic [7:0] sub_diff;
    wire logic [5:0] sub_flags_w;
    wire logic [7:0] dec_val;
    wire logic [7:0] inc_val;
    wire logic [7:0] bit_mask;
    wire logic [7:0] rotr_val;
    wire logic [7:0] rotc_val;
    wire logic [7:0] rlc_val;
    wire logic [7:0] swap_val;
    wire logic       is_skip;

    logic [7:0] res;
    logic       wr_work;
    logic       wr_mem;
    logic       wr_sub_flags;
    logic       wr_carry;
    logic       new_carry;
    logic       do_skip;

    function automatic logic is_zero(input logic [7:0] v);
        return v == exec_pkg::ZERO_BYTE;
    endfunction : is_zero

    assign op       = exec_pkg::op_type'(op_code);
    assign cy       = flag_reg[exec_pkg::CY_POS];
    // Dummy slot after a taken skip, and second cycle of a skip, are not live
    assign live     = op_valid & ~squash_next & ~second_cycle;
    assign rlc_val  = {mem_rdata[6:0], cy};
    assign rotr_val = {mem_rdata[0], mem_rdata[7:1]};
    assign rotc_val = {cy, mem_rdata[7:1]};
    assign swap_val = {mem_rdata[3:0], mem_rdata[7:4]};
    assign dec_val  = mem_rdata - 8'h01;
    assign inc_val  = mem_rdata + 8'h01;
    assign bit_mask = 8'h01 << bit_sel;
    assign is_skip  = (op == exec_pkg::dec_skip_zero_mem) | (op == exec_pkg::dec_skip_zero_to_work)
                    | (op == exec_pkg::inc_skip_zero_mem) | (op == exec_pkg::inc_skip_zero_to_work)
                    | (op == exec_pkg::skip_nonzero_bit)  | (op == exec_pkg::skip_nonzero_test);
    assign sub_rhs  = (op == exec_pkg::sub_borrow_imm || op == exec_pkg::sub_imm_op) ? imm_data : mem_rdata;
    assign sub_bin  = (op == exec_pkg::sub_borrow_op || op == exec_pkg::sub_borrow_imm
                    || op == exec_pkg::sub_borrow_to_mem) ? ~cy : 1'b0;

    sub_flags sub_flags_i (
        .minuend       (work_reg),
        .subtrahend    (sub_rhs),
        .borrow_in     (sub_bin),
        .chain_zero_in (flag_reg[exec_pkg::ZF_POS]),
        .diff          (sub_diff),
        .flags         (sub_flags_w)
    );

    skip_seq skip_seq_i (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .skip_instr   ((live & is_skip) | second_cycle),
        .skip_taken   (do_skip),
        .second_cycle (second_cycle),
        .squash_next  (squash_next)
    );

    always_comb begin
        res          = exec_pkg::ZERO_BYTE;
        wr_work      = 1'b0;
        wr_mem       = 1'b0;
        wr_sub_flags = 1'b0;
        wr_carry     = 1'b0;
        new_carry    = cy;
        do_skip      = 1'b0;
        case (op)
            exec_pkg::rotate_left_thru_cy_to_work: begin
                res       = rlc_val;
                wr_work   = 1'b1;
                wr_carry  = 1'b1;
                new_carry = mem_rdata[7];
            end
            exec_pkg::rotate_right_mem: begin
                res    = rotr_val;
                wr_mem = 1'b1;
            end
            exec_pkg::rotate_right_to_work: begin
                res     = rotr_val;
                wr_work = 1'b1;
            end
            exec_pkg::rotate_right_thru_cy_mem: begin
                res       = rotc_val;
                wr_mem    = 1'b1;
                wr_carry  = 1'b1;
                new_carry = mem_rdata[0];
            end
            exec_pkg::rotate_right_thru_cy_to_work: begin
                res       = rotc_val;
                wr_work   = 1'b1;
                wr_carry  = 1'b1;
                new_carry = mem_rdata[0];
            end
            exec_pkg::sub_borrow_op: begin
                res          = sub_diff;
                wr_work      = 1'b1;
                wr_sub_flags = 1'b1;
            end
            exec_pkg::sub_borrow_imm: begin
                res          = sub_diff;
                wr_work      = 1'b1;
                wr_sub_flags = 1'b1;
            end
            exec_pkg::sub_borrow_to_mem: begin
                res          = sub_diff;
                wr_mem       = 1'b1;
                wr_sub_flags = 1'b1;
            end
            exec_pkg::sub_mem_op: begin
                res          = sub_diff;
                wr_work      = 1'b1;
                wr_sub_flags = 1'b1;
            end
            exec_pkg::minus_to_mem: begin
                res          = sub_diff;
                wr_mem       = 1'b1;
                wr_sub_flags = 1'b1;
            end
            exec_pkg::sub_imm_op: begin
                res          = sub_diff;
                wr_work      = 1'b1;
                wr_sub_flags = 1'b1;
            end
            exec_pkg::dec_skip_zero_mem: begin
                res     = dec_val;
                wr_mem  = 1'b1;
                do_skip = is_zero(dec_val);
            end
            exec_pkg::dec_skip_zero_to_work: begin
                res     = dec_val;
                wr_work = 1'b1;
                do_skip = is_zero(dec_val);
            end
            exec_pkg::inc_skip_zero_mem: begin
                res     = inc_val;
                wr_mem  = 1'b1;
                do_skip = is_zero(inc_val);
            end
            exec_pkg::inc_skip_zero_to_work: begin
                res     = inc_val;
                wr_work = 1'b1;
                do_skip = is_zero(inc_val);
            end
            exec_pkg::skip_nonzero_bit: begin
                do_skip = |(mem_rdata & bit_mask);
            end
            exec_pkg::skip_nonzero_test: begin
                // The byte is rewritten unchanged, matching the read-modify-write path
                res     = mem_rdata;
                wr_mem  = 1'b1;
                do_skip = ~is_zero(mem_rdata);
            end
            exec_pkg::set_byte_op: begin
                res    = exec_pkg::ALL_ONES;
                wr_mem = 1'b1;
            end
            exec_pkg::set_bit_op: begin
                res    = mem_rdata | bit_mask;
                wr_mem = 1'b1;
            end
            exec_pkg::nibble_exchange_mem: begin
                res    = swap_val;
                wr_mem = 1'b1;
            end
            exec_pkg::nibble_exchange_to_work: begin
                res     = swap_val;
                wr_work = 1'b1;
            end
            default: begin
                res = exec_pkg::ZERO_BYTE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            work_reg      <= exec_pkg::WORK_RESET;
            flag_reg      <= exec_pkg::FLAG_RESET;
            mem_we_reg    <= 1'b0;
            mem_wdata_reg <= exec_pkg::ZERO_BYTE;
            busy_reg      <= 1'b0;
            skip_reg      <= 1'b0;
        end else begin
            mem_we_reg    <= live & wr_mem;
            mem_wdata_reg <= res;
            busy_reg      <= live & is_skip;
            skip_reg      <= live & do_skip;
            if (live && wr_work) begin
                work_reg <= res;
            end
            if (live && wr_sub_flags) begin
                flag_reg <= sub_flags_w;
            end else if (live && wr_carry) begin
                flag_reg[exec_pkg::CY_POS] <= new_carry;
            end
        end
    end

    assign working_register = work_reg;
    assign status_flags     = flag_reg;
    assign mem_we           = mem_we_reg;
    assign mem_wdata        = mem_wdata_reg;
    assign busy             = busy_reg;
    assign skip_pulse       = skip_reg;

    AST_SUB_CARRY: assert property (@(posedge mclk) disable iff (!rst_n)
        (op_valid && !squash_next && !second_cycle && op == exec_pkg::sub_mem_op)
        |=> status_flags[exec_pkg::CY_POS] == ($past(work_reg) >= $past(mem_rdata)))
        else $error("carry not inverted borrow");
    AST_SUB_RESULT: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::sub_mem_op) |=> working_register == $past(work_reg - mem_rdata))
        else $error("subtract result wrong");
    AST_ROTR_MEM: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::rotate_right_mem)
        |=> mem_we && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])} && $stable(status_flags))
        else $error("right rotate memory wrong");
    AST_RLC_CARRY: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::rotate_left_thru_cy_to_work)
        |=> status_flags[exec_pkg::CY_POS] == $past(mem_rdata[7]) && !mem_we)
        else $error("left rotate carry wrong");
    AST_SKIP_TWO: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && is_skip) |=> busy ##1 !busy)
        else $error("skip not two cycles");
    AST_DUMMY_QUIET: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && is_skip && do_skip) |=> ##2 !mem_we && $stable(working_register))
        else $error("dummy slot wrote state");
    AST_SET_BYTE: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::set_byte_op) |=> mem_we && mem_wdata == exec_pkg::ALL_ONES)
        else $error("byte set wrong");
    AST_DEC_SKIP: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::dec_skip_zero_mem) |=> skip_pulse == ($past(mem_rdata) == 8'h01))
        else $error("decrement skip wrong");
    AST_ROTR_WORK: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::rotate_right_to_work)
        |=> !mem_we && working_register == {$past(mem_rdata[0]), $past(mem_rdata[7:1])} && $stable(status_flags))
        else $error("right rotate to working register wrong");
    AST_ROTR_CY_MEM: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::rotate_right_thru_cy_mem)
        |=> mem_we && mem_wdata == {$past(cy), $past(mem_rdata[7:1])}
            && status_flags[exec_pkg::CY_POS] == $past(mem_rdata[0]))
        else $error("right rotate memory through carry wrong");
    AST_ROTR_CY_WORK: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::rotate_right_thru_cy_to_work)
        |=> !mem_we && working_register == {$past(cy), $past(mem_rdata[7:1])}
            && status_flags[exec_pkg::CY_POS] == $past(mem_rdata[0]))
        else $error("right rotate to working through carry wrong");
    AST_BORROW_RESULT: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::sub_borrow_op)
        |=> !mem_we && working_register == $past(work_reg - mem_rdata - {7'h00, ~cy}))
        else $error("borrow subtract result wrong");
    AST_BORROW_IMM: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::sub_borrow_imm)
        |=> !mem_we && working_register == $past(work_reg - imm_data - {7'h00, ~cy}))
        else $error("borrow subtract immediate wrong");
    AST_BORROW_MEM: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::sub_borrow_to_mem)
        |=> mem_we && mem_wdata == $past(work_reg - mem_rdata - {7'h00, ~cy}) && $stable(working_register))
        else $error("borrow subtract to memory wrong");
    AST_MINUS_MEM: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::minus_to_mem)
        |=> mem_we && mem_wdata == $past(work_reg - mem_rdata) && $stable(working_register))
        else $error("subtract to memory wrong");
    AST_SUB_IMM: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::sub_imm_op) |=> !mem_we && working_register == $past(work_reg - imm_data))
        else $error("subtract immediate wrong");
    AST_HALF_CARRY: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && wr_sub_flags)
        |=> status_flags[exec_pkg::HC_POS]
            == ({1'b0, $past(work_reg[3:0])} >= {1'b0, $past(sub_rhs[3:0])} + {4'h0, $past(sub_bin)}))
        else $error("half carry wrong");
    AST_DEC_WORK: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::dec_skip_zero_to_work)
        |=> !mem_we && working_register == $past(mem_rdata) - 8'h01 && $stable(status_flags))
        else $error("decrement to working wrong");
    AST_INC_SKIP: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::inc_skip_zero_mem)
        |=> mem_we && skip_pulse == ($past(mem_rdata) == exec_pkg::ALL_ONES) && $stable(status_flags))
        else $error("increment skip wrong");
    AST_BIT_SKIP: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::skip_nonzero_bit) |=> !mem_we && skip_pulse == $past(mem_rdata[bit_sel]))
        else $error("bit test skip wrong");
    AST_TEST_REWRITE: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::skip_nonzero_test)
        |=> mem_we && mem_wdata == $past(mem_rdata) && skip_pulse == ($past(mem_rdata) != 8'h00))
        else $error("byte test skip wrong");
    AST_SET_BIT: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::set_bit_op)
        |=> mem_we && mem_wdata == ($past(mem_rdata) | (8'h01 << $past(bit_sel))) && $stable(status_flags))
        else $error("bit set wrong");
    AST_SWAP_WORK: assert property (@(posedge mclk) disable iff (!rst_n)
        (live && op == exec_pkg::nibble_exchange_to_work)
        |=> !mem_we && working_register == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
        else $error("nibble exchange to working wrong");
endmodule : rot_sub_skip_exec

// *** shared/exec_pkg.sv ***
// Constants and operation codes for the rotate, subtract and skip execution unit
package exec_pkg;

    localparam int DATA_W = 8;
    localparam logic [7:0] ALL_ONES   = 8'hFF;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;
    localparam logic [7:0] WORK_RESET = 8'h00;

    // Status flag positions
    localparam int FLAG_W   = 6;
    localparam int CY_POS      = 0;
    localparam int HC_POS      = 1;
    localparam int ZF_POS      = 2;
    localparam int RANGE_POS   = 3;
    localparam int SIGN_CY_POS = 4;
    localparam int CHAIN_Z_POS = 5;
    localparam logic [5:0] FLAG_RESET = 6'h00;

    localparam int OP_W = 5;

    typedef enum logic [4:0] {
        op_nop,
        rotate_left_thru_cy_to_work,
        rotate_right_mem,
        rotate_right_to_work,
        rotate_right_thru_cy_mem,
        rotate_right_thru_cy_to_work,
        sub_borrow_op,
        sub_borrow_imm,
        sub_borrow_to_mem,
        sub_mem_op,
        minus_to_mem,
        sub_imm_op,
        dec_skip_zero_mem,
        dec_skip_zero_to_work,
        inc_skip_zero_mem,
        inc_skip_zero_to_work,
        skip_nonzero_bit,
        skip_nonzero_test,
        set_byte_op,
        set_bit_op,
        nibble_exchange_mem,
        nibble_exchange_to_work
    } op_type;

endpackage : exec_pkg

// *** hdl/sub_flags.sv ***
// Subtractor that forms the difference and the six subtraction flags
`timescale 1ns/1ns
module sub_flags (
    // Operands
    input  wire logic [7:0] minuend,
    input  wire logic [7:0] subtrahend,
    input  wire logic       borrow_in,
    input  wire logic       chain_zero_in,
    // Results
    output logic      [7:0] diff,
    output logic      [5:0] flags
);
    wire logic [8:0] full_diff;
    wire logic [4:0] low_diff;
    wire logic [8:0] full_low6;
    wire logic       zero_now;

    assign full_diff = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
    assign low_diff  = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
    assign full_low6 = {2'b00, minuend[6:0]} - {2'b00, subtrahend[6:0]} - {8'h00, borrow_in};
    assign diff      = full_diff[7:0];
    assign zero_now  = (full_diff[7:0] == exec_pkg::ZERO_BYTE);

    always_comb begin
        flags = exec_pkg::FLAG_RESET;
        // Carry set when no borrow occurred
        flags[exec_pkg::CY_POS] = ~full_diff[8];
        flags[exec_pkg::HC_POS] = ~low_diff[4];
        flags[exec_pkg::ZF_POS] = zero_now;
        flags[exec_pkg::RANGE_POS]   = full_diff[8] ^ full_low6[7];
        flags[exec_pkg::SIGN_CY_POS] = ~(full_diff[8] ^ full_low6[7]) ^ full_diff[7];
        flags[exec_pkg::CHAIN_Z_POS] = zero_now & chain_zero_in;
    end
endmodule : sub_flags

// *** hdl/skip_seq.sv ***
// Two-cycle sequencer for skip instructions and the dummy slot after a skip
`timescale 1ns/1ns
module skip_seq (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Control
    input  wire logic skip_instr,
    input  wire logic skip_taken,
    // Status
    output logic      second_cycle,
    output logic      squash_next
);
    logic second_reg;
    logic taken_reg;
    logic squash_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            second_reg <= 1'b0;
            taken_reg  <= 1'b0;
            squash_reg <= 1'b0;
        end else begin
            second_reg <= skip_instr & ~second_reg;
            taken_reg  <= skip_instr & ~second_reg & skip_taken;
            // The dummy slot follows the second cycle, so the decision waits one cycle
            squash_reg <= second_reg & taken_reg;
        end
    end

    assign second_cycle = second_reg;
    assign squash_next  = squash_reg;
endmodule : skip_seq

// *** sim/data_mem_model.sv ***
// Behavioural data memory byte and preload port seen by the execution unit
`timescale 1ns/1ns
module data_mem_model (
    // Clock
    input  wire logic       mclk,
    // Bench preload
    input  wire logic       load_en,
    input  wire logic [7:0] load_data,
    // Memory ports
    input  wire logic       mem_we,
    input  wire logic [7:0] mem_wdata,
    output logic      [7:0] mem_rdata
);
    // One addressed location is enough: every op here names a single byte
    logic [7:0] mem_reg = 8'h00;

    assign mem_rdata = mem_reg;

    // A preload wins over a write so the bench always starts from a known byte
    always @(posedge mclk) begin
        if (load_en) begin
            mem_reg <= load_data;
        end else if (mem_we) begin
            mem_reg <= mem_wdata;
        end
    end
endmodule : data_mem_model

// *** sim/mcu_rotate_subtract_skip_exec_test.sv ***
// Self-checking testbench for the rotate, subtract and skip execution unit
`timescale 1ns/1ns
module mcu_rotate_subtract_skip_exec_test;
    logic       mclk     = 1'b0;
    logic       rst_n    = 1'b0;
    logic       op_valid = 1'b0;
    logic [4:0] op_code  = 5'h00;
    logic [7:0] imm_data = 8'h00;
    logic [2:0] bit_sel  = 3'h0;
    logic       load_en  = 1'b0;
    logic [7:0] load_data = 8'h00;
    logic [7:0] mem_rdata;
    logic       mem_we;
    logic [7:0] mem_wdata;
    logic [7:0] working_register;
    logic [5:0] status_flags;
    logic       busy;
    logic       skip_pulse;
    logic [5:0] flg;
    logic [7:0] wprev;
    logic       exp_cy = 1'b0;
    int         bad_count = 0;
    int         checks = 0;
    localparam logic [5:0] KEEP = ~(6'h01 << exec_pkg::CY_POS);

    always #2 mclk = ~mclk;

    rot_sub_skip_exec rot_sub_skip_exec_i (.mclk(mclk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
        .imm_data(imm_data), .bit_sel(bit_sel), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata),
        .working_register(working_register), .status_flags(status_flags), .busy(busy), .skip_pulse(skip_pulse));
    data_mem_model data_mem_model_i (.mclk(mclk), .load_en(load_en), .load_data(load_data), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task automatic set_mem(input logic [7:0] v);
        @(posedge mclk);
        load_en   <= 1'b1;
        load_data <= v;
        @(posedge mclk);
        load_en   <= 1'b0;
    endtask : set_mem

    task automatic do_op(input exec_pkg::op_type op, input logic [7:0] imm, input logic [2:0] bsel);
        flg = status_flags;
        @(posedge mclk);
        op_valid <= 1'b1;
        op_code  <= op;
        imm_data <= imm;
        bit_sel  <= bsel;
        @(posedge mclk);
        op_valid <= 1'b0;
        #1;
    endtask : do_op

    task automatic expect_out(input logic we, input logic [7:0] wd, input logic [7:0] w);
        check("mem_we", {7'h00, we}, {7'h00, mem_we});
        if (we)
            check("mem_wdata", wd, mem_wdata);
        check("working_register", w, working_register);
    endtask : expect_out

    // Carry against the tracked value, every other flag against the snapshot
    task automatic expect_flags();
        check("carry", {7'h00, exp_cy}, {7'h00, status_flags[exec_pkg::CY_POS]});
        check("other flags", {2'b00, flg & KEEP}, {2'b00, status_flags & KEEP});
    endtask : expect_flags

    task automatic set_work(input logic [7:0] v);
        set_mem({v[6:0], v[7]});
        do_op(exec_pkg::rotate_right_to_work, 8'h00, 3'h0);
        expect_out(1'b0, 8'h00, v);
        expect_flags();
    endtask : set_work

    task automatic test_reset();
        #1;
        expect_out(1'b0, 8'h00, exec_pkg::WORK_RESET);
        check("flags", {2'b00, exec_pkg::FLAG_RESET}, {2'b00, status_flags});
        check("busy", 8'h00, {7'h00, busy});
        $display("test_reset done");
    endtask : test_reset

    task automatic test_rotates();
        set_mem(8'h81);
        do_op(exec_pkg::rotate_left_thru_cy_to_work, 8'h00, 3'h0);
        exp_cy = 1'b1;
        expect_out(1'b0, 8'h00, 8'h02);
        expect_flags();
        set_mem(8'h80);
        do_op(exec_pkg::rotate_right_thru_cy_to_work, 8'h00, 3'h0);
        exp_cy = 1'b0;
        expect_out(1'b0, 8'h00, 8'hC0);
        expect_flags();
        do_op(exec_pkg::rotate_right_mem, 8'h00, 3'h0);
        expect_out(1'b1, 8'h40, 8'hC0);
        expect_flags();
        set_mem(8'h01);
        do_op(exec_pkg::rotate_right_thru_cy_mem, 8'h00, 3'h0);
        exp_cy = 1'b1;
        expect_out(1'b1, 8'h00, 8'hC0);
        expect_flags();
        $display("test_rotates done");
    endtask : test_rotates

    task automatic sub_case(input exec_pkg::op_type op, input logic [7:0] w, input logic [7:0] m);
        logic       imm_op;
        logic       to_mem;
        logic [8:0] d;
        imm_op = op inside {exec_pkg::sub_imm_op, exec_pkg::sub_borrow_imm};
        to_mem = op inside {exec_pkg::minus_to_mem, exec_pkg::sub_borrow_to_mem};
        d = {1'b0, w} - {1'b0, m};
        if (op inside {exec_pkg::sub_borrow_op, exec_pkg::sub_borrow_imm, exec_pkg::sub_borrow_to_mem})
            d = d - {8'h00, ~exp_cy};
        set_work(w);
        // Memory holds a decoy for immediate forms
        set_mem(imm_op ? ~m : m);
        do_op(op, imm_op ? m : ~m, 3'h0);
        exp_cy = ~d[8];
        expect_out(to_mem, d[7:0], to_mem ? w : d[7:0]);
        check("carry", {7'h00, exp_cy}, {7'h00, status_flags[exec_pkg::CY_POS]});
        check("zero", {7'h00, d[7:0] == 8'h00}, {7'h00, status_flags[exec_pkg::ZF_POS]});
        check("overflow", {7'h00, (w[7] ^ m[7]) & (w[7] ^ d[7])}, {7'h00, status_flags[exec_pkg::RANGE_POS]});
        check("chained zero", {7'h00, (d[7:0] == 8'h00) & flg[exec_pkg::ZF_POS]},
              {7'h00, status_flags[exec_pkg::CHAIN_Z_POS]});
    endtask : sub_case

    task automatic test_subtract();
        exec_pkg::op_type ops [6] = '{exec_pkg::sub_mem_op, exec_pkg::minus_to_mem, exec_pkg::sub_imm_op,
            exec_pkg::sub_borrow_op, exec_pkg::sub_borrow_imm, exec_pkg::sub_borrow_to_mem};
        for (int i = 0; i < 6; i++) begin
            sub_case(ops[i], 8'h10, 8'h20);
            sub_case(ops[i], 8'h35, 8'h35);
            sub_case(ops[i], 8'h35, 8'h35);
            sub_case(ops[i], 8'h80, 8'h01);
        end
        $display("test_subtract done");
    endtask : test_subtract

    // kind: 0 no write, 1 memory write, 2 working register; a write op waits in the refused slots
    task automatic skip_case(input exec_pkg::op_type op, input logic [7:0] m, input logic [2:0] bsel,
                             input logic [7:0] res, input int kind, input logic skip);
        int n;
        set_mem(m);
        flg = status_flags;
        wprev = working_register;
        n = skip ? 2 : 1;
        @(posedge mclk);
        op_valid <= 1'b1;
        op_code  <= op;
        bit_sel  <= bsel;
        @(posedge mclk);
        op_code  <= exec_pkg::set_byte_op;
        #1;
        check("busy", 8'h01, {7'h00, busy});
        check("skip_pulse", {7'h00, skip}, {7'h00, skip_pulse});
        expect_out(kind == 1, res, (kind == 2) ? res : wprev);
        expect_flags();
        wprev = working_register;
        for (int k = 1; k <= n; k++) begin
            @(posedge mclk);
            if (k == n)
                op_valid <= 1'b0;
            #1;
            expect_out(1'b0, 8'h00, wprev);
        end
    endtask : skip_case

    task automatic test_skips();
        skip_case(exec_pkg::dec_skip_zero_mem, 8'h01, 3'h0, 8'h00, 1, 1'b1);
        skip_case(exec_pkg::dec_skip_zero_mem, 8'h00, 3'h0, 8'hFF, 1, 1'b0);
        skip_case(exec_pkg::dec_skip_zero_to_work, 8'h01, 3'h0, 8'h00, 2, 1'b1);
        skip_case(exec_pkg::dec_skip_zero_to_work, 8'h80, 3'h0, 8'h7F, 2, 1'b0);
        skip_case(exec_pkg::inc_skip_zero_mem, 8'hFF, 3'h0, 8'h00, 1, 1'b1);
        skip_case(exec_pkg::inc_skip_zero_mem, 8'h7F, 3'h0, 8'h80, 1, 1'b0);
        skip_case(exec_pkg::inc_skip_zero_to_work, 8'hFF, 3'h0, 8'h00, 2, 1'b1);
        skip_case(exec_pkg::inc_skip_zero_to_work, 8'h00, 3'h0, 8'h01, 2, 1'b0);
        skip_case(exec_pkg::skip_nonzero_bit, 8'h08, 3'h3, 8'h00, 0, 1'b1);
        skip_case(exec_pkg::skip_nonzero_bit, 8'hF7, 3'h3, 8'h00, 0, 1'b0);
        skip_case(exec_pkg::skip_nonzero_bit, 8'h80, 3'h7, 8'h00, 0, 1'b1);
        skip_case(exec_pkg::skip_nonzero_test, 8'h5A, 3'h0, 8'h5A, 1, 1'b1);
        skip_case(exec_pkg::skip_nonzero_test, 8'h00, 3'h0, 8'h00, 1, 1'b0);
        $display("test_skips done");
    endtask : test_skips

    task automatic test_set_swap();
        set_mem(8'h12);
        wprev = working_register;
        do_op(exec_pkg::set_byte_op, 8'h00, 3'h0);
        expect_out(1'b1, exec_pkg::ALL_ONES, wprev);
        expect_flags();
        set_mem(8'h9B);
        do_op(exec_pkg::set_bit_op, 8'h00, 3'h2);
        expect_out(1'b1, 8'h9F, wprev);
        expect_flags();
        set_mem(8'h3C);
        do_op(exec_pkg::nibble_exchange_mem, 8'h00, 3'h0);
        expect_out(1'b1, 8'hC3, wprev);
        expect_flags();
        do_op(exec_pkg::nibble_exchange_to_work, 8'h00, 3'h0);
        expect_out(1'b0, 8'h00, 8'h3C);
        expect_flags();
        $display("test_set_swap done");
    endtask : test_set_swap

    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        test_reset();
        test_rotates();
        test_subtract();
        test_skips();
        test_set_swap();
        end_of_test();
    end

    // A hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        end_of_test();
    end
endmodule : mcu_rotate_subtract_skip_exec_test
